// ### pkg/omc_pkg.sv
// Constants and types of the operating mode select block.
// Assumes one system clock and a synchronous active-high reset.
// Operation
// - Mode comes from two pins, modes 1-3.
// - Mode 1: normal addressing, ROM off, expanded.
// - Modes 2/3 ROM on; 2 advanced, 3 normal.
// - Modes 2/3 start single-chip; extended_mode_enable bit expands.
// - Extended_mode_enable bit is bit 7; forced 1 in mode 1.
// - Extended_mode_enable bit read/write, resets 0 in 2/3.
// - Bits 6..2 read zero, ignore writes.
// - Bits 1,0 are read-only pin level copies.
// - Pin levels latched when register is read.
// - Reset releases the mode level latches.
// - Reset values follow the mode pin levels.
package omc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] MODE_CONTROL_OFS = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;
    localparam int         EXTENDED_MODE_ENABLE_BIT         = 7;
    localparam int         RSVD_HI_BIT      = 6;
    localparam int         RSVD_LO_BIT      = 2;
    localparam int         LEVEL_HI_BIT     = 1;
    localparam int         LEVEL_LO_BIT     = 0;
    localparam logic [4:0] RSVD_VALUE       = 5'h00;

    // ----------------------------------------
    // Modes and reset values
    // ----------------------------------------
    localparam logic [1:0] MODE0          = 2'h0;
    localparam logic [1:0] MODE1          = 2'h1;
    localparam logic [1:0] MODE2          = 2'h2;
    localparam logic [1:0] MODE3          = 2'h3;
    localparam logic       EXTENDED_MODE_ENABLE_SINGLE    = 1'h0;
    localparam logic       EXTENDED_MODE_ENABLE_FORCED    = 1'h1;
    localparam int         SYNC_STAGES    = 3;
    localparam int         RST_MIN_CYCLES = 4;

    typedef enum logic [1:0] {
        LAT_FREE = 2'h1,
        LAT_HELD = 2'h2
    } omc_lat_t;

endpackage

// ### pkg/omc_mode_if.sv
// Interface between the mode pin synchroniser, decoder and core.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface omc_mode_if;
    logic [1:0] pinLevels;
    logic [1:0] strapMode;
    logic       advancedAddr;
    logic       romOn;
    logic       forceExpanded;
    logic       modeUsable;

    modport sync (output pinLevels);
    modport dec  (input strapMode, output advancedAddr, romOn,
                  forceExpanded, modeUsable);
    modport core (input pinLevels, advancedAddr, romOn, forceExpanded,
                  modeUsable, output strapMode);
endinterface
`default_nettype wire

// ### rtl/omc_pin_sync.sv
// Three-stage synchroniser for the two mode pins.
// Assumes pins are asynchronous straps; no reset so levels reach reset.
`timescale 1ns/1ps
`default_nettype none
module omc_pin_sync
    import omc_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Pins
    input  wire logic modePinHi,
    input  wire logic modePinLo,
    // Settled levels
    omc_mode_if.sync  modeIf
);
    logic [1:0] stage1_reg;
    logic [1:0] stage2_reg;
    logic [1:0] stage3_reg;
    logic [1:0] settled_reg;
    wire        agree = (stage2_reg == stage3_reg);

    // Settled level moves only when the two late stages agree
    always_ff @(posedge clk) begin
        stage1_reg <= {modePinHi, modePinLo};
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
        if (agree) begin
            settled_reg <= stage3_reg;
        end
    end

    assign modeIf.pinLevels = settled_reg;
endmodule
`default_nettype wire

// ### rtl/omc_mode_decode.sv
// Decode of the strapped mode into CPU, ROM and bus settings.
// Assumes the strap code is stable between resets.
`timescale 1ns/1ps
`default_nettype none
module omc_mode_decode
    import omc_pkg::*;
(
    // Mode signals
    omc_mode_if.dec modeIf
);
    wire logic isMode1 = (modeIf.strapMode == MODE1);
    wire logic isMode2 = (modeIf.strapMode == MODE2);
    wire logic isMode3 = (modeIf.strapMode == MODE3);

    assign modeIf.modeUsable    = isMode1 | isMode2 | isMode3;
    assign modeIf.advancedAddr  = isMode2;
    assign modeIf.romOn         = isMode2 | isMode3;
    assign modeIf.forceExpanded = isMode1;
endmodule
`default_nettype wire

// ### rtl/omc_mode_select.sv
// Operating mode select: mode strap, mode control register, outputs.
// Assumes a one-cycle strobe register port and straps that stay put.
`timescale 1ns/1ps
`default_nettype none
module omc_mode_select
    import omc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Mode pins
    input  wire logic              modePinHi,
    input  wire logic              modePinLo,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrStrobe,
    input  wire logic              regRdStrobe,
    output logic      [7:0]        regRdData,
    // Mode outputs
    output logic                   cpuAdvanced,
    output logic                   romEnable,
    output logic                   extBusEnable,
    output logic                   modeFault,
    output logic      [1:0]        latchedLevels
);

    // ----------------------------------------
    // Pin synchroniser and mode decoder
    // ----------------------------------------
    omc_mode_if modeIf ();

    omc_pin_sync u_sync (
        .clk       (clk),
        .modePinHi (modePinHi),
        .modePinLo (modePinLo),
        .modeIf    (modeIf.sync)
    );

    omc_mode_decode u_dec (
        .modeIf (modeIf.dec)
    );

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    logic [1:0]  strapMode_reg;
    logic        extended_mode_enable_reg;
    logic        extended_mode_enable_next;
    omc_lat_t    latState_reg;
    omc_lat_t    latState_next;
    logic [1:0]  levels_reg;
    logic [1:0]  levels_next;
    logic [7:0]  rdData_reg;
    logic [7:0]  rdData_next;
    logic        cpuAdv_reg;
    logic        romEn_reg;
    logic        extBus_reg;
    logic        fault_reg;
    logic        rstSeen_reg;

    wire logic [ADDR_W-1:0] ctrlAddr = ADDR_W'(MODE_CONTROL_OFS);
    wire logic        ctrlHit  = (regAddr == ctrlAddr);
    wire logic        wrHit    = regWrStrobe & ctrlHit;
    wire logic        rdHit    = regRdStrobe & ctrlHit;
    wire logic        forced   = modeIf.forceExpanded;
    wire logic        rstMode1 = (modeIf.pinLevels == MODE1);
    wire logic        rstMode2 = (modeIf.pinLevels == MODE2);
    wire logic        rstMode3 = (modeIf.pinLevels == MODE3);
    wire logic        newExpe  = regWrData[EXTENDED_MODE_ENABLE_BIT];
    wire logic [7:0]  ctrlView;

    // Strap is taken from the settled pins while reset is held
    assign modeIf.strapMode = strapMode_reg;

    // ----------------------------------------
    // Extended mode enable
    // ----------------------------------------
    // Forced designs ignore writes; a write lands at the next edge
    always_comb begin
        extended_mode_enable_next = extended_mode_enable_reg;
        if (forced) begin
            extended_mode_enable_next = EXTENDED_MODE_ENABLE_FORCED;
        end else if (wrHit) begin
            extended_mode_enable_next = newExpe;
        end
    end

    property p_extended_mode_enable_hold;
        @(posedge clk) disable iff (sys_rst)
        !wrHit && !forced |=> $stable(extBusEnable);
    endproperty
    a_extended_mode_enable_hold: assert property (p_extended_mode_enable_hold)
        else $error("Expanded mode changed without a write");

    property p_mode1_ignore;
        @(posedge clk) disable iff (sys_rst)
        forced && wrHit && !newExpe |=> extBusEnable;
    endproperty
    a_mode1_ignore: assert property (p_mode1_ignore)
        else $error("Write cleared extended_mode_enable in mode 1");

    // ----------------------------------------
    // Mode level latch
    // ----------------------------------------
    // Free latch follows the pins; a read captures and holds them
    always_comb begin
        latState_next = latState_reg;
        levels_next   = levels_reg;
        case (latState_reg)
            LAT_FREE: begin
                levels_next = modeIf.pinLevels;
                if (rdHit) begin
                    latState_next = LAT_HELD;
                end
            end
            LAT_HELD: begin
                if (rdHit) begin
                    levels_next = modeIf.pinLevels;
                end
            end
            default: begin
                latState_next = LAT_FREE;
                levels_next   = modeIf.pinLevels;
            end
        endcase
    end

    property p_read_holds;
        @(posedge clk) disable iff (sys_rst)
        rdHit |=> latState_reg == LAT_HELD;
    endproperty
    a_read_holds: assert property (p_read_holds)
        else $error("Read did not capture the mode levels");

    property p_level_ro;
        @(posedge clk) disable iff (sys_rst)
        wrHit |=> $stable(latchedLevels);
    endproperty
    a_level_ro: assert property (p_level_ro)
        else $error("Write changed the mode level bits");

    // Reserved field reads as zero whatever was written
    assign ctrlView = {extended_mode_enable_next, RSVD_VALUE, levels_next};

    // Data stands only in the cycle after the read strobe
    always_comb begin
        rdData_next = 8'h00;
        if (regRdStrobe) begin
            rdData_next = ctrlHit ? ctrlView : UNMAPPED_READ;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Strap is frozen at the last reset edge; pins must settle by then
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strapMode_reg <= modeIf.pinLevels;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extended_mode_enable_reg <= rstMode1 ? EXTENDED_MODE_ENABLE_FORCED : EXTENDED_MODE_ENABLE_SINGLE;
        end else begin
            extended_mode_enable_reg <= extended_mode_enable_next;
        end
    end

    // Reset frees the latch so it resamples the pins afresh
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latState_reg <= LAT_FREE;
            levels_reg   <= modeIf.pinLevels;
        end else begin
            latState_reg <= latState_next;
            levels_reg   <= levels_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    // Reset values match the decode, so no step at release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpuAdv_reg <= rstMode2;
            romEn_reg  <= rstMode2 | rstMode3;
            extBus_reg <= rstMode1;
            fault_reg  <= (modeIf.pinLevels == MODE0);
        end else begin
            cpuAdv_reg <= modeIf.advancedAddr;
            romEn_reg  <= modeIf.romOn;
            extBus_reg <= forced | extended_mode_enable_next;
            fault_reg  <= ~modeIf.modeUsable;
        end
    end

    always_ff @(posedge clk) begin
        rstSeen_reg <= sys_rst;
    end

    property p_strap_frozen;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> $stable(strapMode_reg);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen)
        else $error("Strap mode moved outside reset");

    property p_reset_levels;
        @(posedge clk) disable iff (sys_rst)
        rstSeen_reg |-> latchedLevels == strapMode_reg
            && cpuAdvanced == (strapMode_reg == MODE2);
    endproperty
    a_reset_levels: assert property (p_reset_levels)
        else $error("Reset levels not taken from mode pins");

    property p_mode_steady;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> $stable(romEnable) && $stable(cpuAdvanced)
            && $stable(modeFault);
    endproperty
    a_mode_steady: assert property (p_mode_steady)
        else $error("Mode outputs moved outside reset");

    property p_read_extended_mode_enable;
        @(posedge clk) disable iff (sys_rst)
        rdHit |=> regRdData[EXTENDED_MODE_ENABLE_BIT] == extBusEnable;
    endproperty
    a_read_extended_mode_enable: assert property (p_read_extended_mode_enable)
        else $error("Read extended_mode_enable disagrees with bus mode");

    property p_usable_mode;
        @(posedge clk) disable iff (sys_rst)
        !modeFault |-> romEnable || extBusEnable;
    endproperty
    a_usable_mode: assert property (p_usable_mode)
        else $error("Usable mode with neither ROM nor bus");

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdData     = rdData_reg;
    assign cpuAdvanced   = cpuAdv_reg;
    assign romEnable     = romEn_reg;
    assign extBusEnable  = extBus_reg;
    assign modeFault     = fault_reg;
    assign latchedLevels = levels_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_extended_mode_enable_write;
        @(posedge clk) disable iff (sys_rst)
        wrHit && newExpe |=> extBusEnable;
    endproperty
    a_extended_mode_enable_write: assert property (p_extended_mode_enable_write)
        else $error("Write of extended_mode_enable did not expand the bus");

    property p_extended_mode_enable_clear;
        @(posedge clk) disable iff (sys_rst)
        wrHit && !newExpe && !forced |=> !extBusEnable;
    endproperty
    a_extended_mode_enable_clear: assert property (p_extended_mode_enable_clear)
        else $error("Clearing extended_mode_enable did not return to single-chip");

    property p_mode1_forced;
        @(posedge clk) disable iff (sys_rst)
        strapMode_reg == MODE1 |=> extBusEnable && !romEnable
            && !cpuAdvanced;
    endproperty
    a_mode1_forced: assert property (p_mode1_forced)
        else $error("Mode 1 outputs wrong");

    property p_mode1_read;
        @(posedge clk) disable iff (sys_rst)
        rdHit && strapMode_reg == MODE1 |=> regRdData[EXTENDED_MODE_ENABLE_BIT];
    endproperty
    a_mode1_read: assert property (p_mode1_read)
        else $error("Extended_mode_enable read as zero in mode 1");

    property p_rom_modes;
        @(posedge clk) disable iff (sys_rst)
        strapMode_reg == MODE2 || strapMode_reg == MODE3
            |=> romEnable && (cpuAdvanced == $past(strapMode_reg[0] == 1'b0));
    endproperty
    a_rom_modes: assert property (p_rom_modes)
        else $error("ROM or addressing wrong in mode 2 or 3");

    property p_reserved_zero;
        @(posedge clk) disable iff (sys_rst)
        rdHit |=> regRdData[RSVD_HI_BIT:RSVD_LO_BIT] == RSVD_VALUE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits read nonzero");

    property p_level_copy;
        @(posedge clk) disable iff (sys_rst)
        rdHit |=> regRdData[LEVEL_HI_BIT:LEVEL_LO_BIT]
            == $past(modeIf.pinLevels) && latchedLevels == regRdData[1:0];
    endproperty
    a_level_copy: assert property (p_level_copy)
        else $error("Mode levels not captured on read");

    property p_held_latch;
        @(posedge clk) disable iff (sys_rst)
        latState_reg == LAT_HELD && !rdHit |=> $stable(latchedLevels);
    endproperty
    a_held_latch: assert property (p_held_latch)
        else $error("Held mode levels changed without a read");

    property p_release;
        @(posedge clk) disable iff (sys_rst)
        rstSeen_reg |-> latState_reg == LAT_FREE
            && extBusEnable == (strapMode_reg == MODE1);
    endproperty
    a_release: assert property (p_release)
        else $error("Reset state not taken from mode pins");

    property p_single_start;
        @(posedge clk) disable iff (sys_rst)
        rstSeen_reg && strapMode_reg != MODE1 && !wrHit |-> !extBusEnable
            ##1 !extBusEnable;
    endproperty
    a_single_start: assert property (p_single_start)
        else $error("Mode 2 or 3 did not start single-chip");

    property p_unmapped;
        @(posedge clk) disable iff (sys_rst)
        (regRdStrobe && !ctrlHit) || !regRdStrobe |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Read data outside a control read");

    property p_fault;
        @(posedge clk) disable iff (sys_rst)
        ##1 modeFault == ($past(strapMode_reg) == MODE0);
    endproperty
    a_fault: assert property (p_fault)
        else $error("Mode fault does not match strap");

endmodule
`default_nettype wire

// ### test/omc_strap_model.sv
// Board strap model for the mode pins of the mode select block.
// Assumes the strap is chosen by the bench and settles only in reset.
`timescale 1ns/1ps
`default_nettype none
module omc_strap_model
    import omc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Strap chosen by the bench
    input  wire logic [1:0] strapSel,
    // Mode pins
    output logic            modePinHi,
    output logic            modePinLo
);
    // ----------------------------------------
    // Strap
    // ----------------------------------------
    logic [1:0] pickCode;
    logic [1:0] strapCode = MODE1;

    // A request for mode 0 falls back to mode 1: never strapped
    assign pickCode = (strapSel == MODE0) ? MODE1 : strapSel;

    // Jumpers only move while the part is held in reset
    always @(posedge clk) begin
        if (sys_rst) begin
            strapCode <= pickCode;
        end
    end

    assign modePinHi = strapCode[1];
    assign modePinLo = strapCode[0];
endmodule
`default_nettype wire

// ### test/omc_mode_select_bench.sv
// Self-checking bench of the mode select block and its register.
// Assumes the strap model on the pins and a 10 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        nFail++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
end
module omc_mode_select_bench;
    import omc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic       clk         = 1'b0;
    logic       sys_rst     = 1'b1;
    logic [1:0] strapSel    = MODE1;
    logic [7:0] regAddr     = 8'h00;
    logic [7:0] regWrData   = 8'h00;
    logic       regWrStrobe = 1'b0;
    logic       regRdStrobe = 1'b0;
    wire        modePinHi;
    wire        modePinLo;
    wire  [7:0] regRdData;
    wire        cpuAdvanced;
    wire        romEnable;
    wire        extBusEnable;
    wire        modeFault;
    wire  [1:0] latchedLevels;
    int         nFail       = 0;
    int         checked     = 0;
    logic [1:0] mc;
    logic [7:0] d;

    always #50 clk = ~clk;

    omc_strap_model strap (.clk(clk), .sys_rst(sys_rst),
        .strapSel(strapSel), .modePinHi(modePinHi), .modePinLo(modePinLo));

    omc_mode_select #(.ADDR_W(8)) DUT (.clk(clk), .sys_rst(sys_rst),
        .modePinHi(modePinHi), .modePinLo(modePinLo), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .cpuAdvanced(cpuAdvanced), .romEnable(romEnable),
        .extBusEnable(extBusEnable), .modeFault(modeFault),
        .latchedLevels(latchedLevels));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out;
        if (nFail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regWrStrobe <= 1'b1;
        regAddr     <= a;
        regWrData   <= v;
        @(posedge clk);
        regWrStrobe <= 1'b0;
        #1;
    endtask

    // Data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regRdStrobe <= 1'b1;
        regAddr     <= a;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        v = regRdData;
    endtask

    // Ten cycles leave the pin synchroniser time to settle
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk);
        strapSel <= m;
        sys_rst  <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        `CHK("rst levels", m, latchedLevels)
        `CHK("rst expand", m == MODE1, extBusEnable)
        @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        for (int m = 1; m <= 3; m++) begin
            mc = 2'(m);
            do_reset(mc);
            @(posedge clk);
            #1;
            `CHK("advanced", mc == MODE2, cpuAdvanced)
            `CHK("rom", mc != MODE1, romEnable)
            `CHK("expand", mc == MODE1, extBusEnable)
            `CHK("fault", 1'b0, modeFault)
            rd(MODE_CONTROL_OFS, d);
            `CHK("ctl reset", {mc == MODE1, 5'h00, mc}, d)
            `CHK("latch", mc, latchedLevels)
            wr(MODE_CONTROL_OFS, 8'hFF);
            `CHK("expand set", 1'b1, extBusEnable)
            rd(8'h05, d);
            `CHK("unmapped rd", UNMAPPED_READ, d)
            wr(8'h05, 8'h00);
            rd(MODE_CONTROL_OFS, d);
            `CHK("ctl ones", {1'b1, 5'h00, mc}, d)
            wr(MODE_CONTROL_OFS, 8'h00);
            `CHK("expand clr", mc == MODE1, extBusEnable)
            rd(MODE_CONTROL_OFS, d);
            `CHK("ctl zero", {mc == MODE1, 5'h00, mc}, d)
            `CHK("latch again", mc, latchedLevels)
            wr(MODE_CONTROL_OFS, 8'h80);
            // Mid-run reset must drop the enable in modes 2/3 and free the latch
            do_reset(mc);
            rd(MODE_CONTROL_OFS, d);
            `CHK("ctl rerst", {mc == MODE1, 5'h00, mc}, d)
        end
        close_out();
    end

    // Whole run is under 400 cycles
    initial begin
        repeat (3000) @(posedge clk);
        nFail++;
        close_out();
    end
endmodule
`default_nettype wire
